// [verif/sads_afe_model.sv]
// Behavioural analog front end: sample-hold, resistor string and comparator
`timescale 1ns/1ps
`default_nettype none
module sads_afe_model (
	input  wire logic       clk,
	input  wire logic       cmp_power,   // Comparator bias
	input  wire logic       sample_hold, // Track input while high
	input  wire logic [9:0] dac_code,    // Trial code from the sequencer
	input  wire logic [9:0] vin,         // Input level in code units
	output logic            cmp_in       // Decision back to the sequencer
);
	logic [9:0] held;                    // Held sample
	logic       tgl = 1'b0;              // Noise for an unbiased comparator
	// Track while sampling, hold otherwise
	always @(posedge clk) begin
		if (sample_hold) held <= vin;
		tgl <= ~tgl;
	end
	// Held level against trial code; no useful answer when unbiased
	assign cmp_in = cmp_power ? (held >= dac_code) : tgl;
endmodule : sads_afe_model
`default_nettype wire

// [verif/tb_top.sv]
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_top;
	logic        clk = 1'b0;         // System clock
	logic        arst_n = 1'b0;      // Reset, active low
	logic [15:0] cpu_addr = '0;      // Bus address
	logic        cpu_rd = 1'b0;      // Read strobe
	logic        cpu_wr = 1'b0;      // Byte write strobe
	logic        cpu_bit_wr = 1'b0;  // Bit write strobe
	logic [2:0]  cpu_bit_sel = '0;   // Bit number
	logic [7:0]  cpu_wdata = '0;     // Write data
	logic [7:0]  cpu_rdata;          // Read data
	logic        cpu_wait;           // Wait request
	logic        cmp_in;             // Comparator decision
	logic        cmp_power;          // Comparator bias
	logic        sample_hold;        // Sampling window
	logic        irq;                // Completion pulse
	logic        suspect;            // Early-result flag
	logic [9:0]  dac_code;           // Trial code
	logic [9:0]  vin = '0;           // Analog level
	logic [7:0]  rd;                 // Last read value
	int          n_fail = 0;         // Mismatch count
	int          checks = 0;         // Comparison count
	int          cyc;                // Cycles to a completion
	int          i;                  // Row index
	// Rows: mode byte, analog level, conversion period in clocks; allowed time codes only
	int rows [12][3] = '{'{8'h81, 10'h3ff, 264}, '{8'h89, 10'h000, 176}, '{8'h91, 10'h200, 132},
		'{8'h99, 10'h1ff, 88}, '{8'ha1, 10'h155, 66}, '{8'ha9, 10'h2aa, 44},
		'{8'h83, 10'h001, 480}, '{8'h8b, 10'h3fe, 320}, '{8'h93, 10'h100, 240},
		'{8'h9b, 10'h0c3, 160}, '{8'ha3, 10'h37f, 120}, '{8'hab, 10'h040, 80}};

	// Clock, 10 ns period
	always #5 clk = ~clk;

	sads_top i_dut (.clk(clk), .arst_n(arst_n), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
		.cpu_bit_wr(cpu_bit_wr), .cpu_bit_sel(cpu_bit_sel), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
		.cpu_wait(cpu_wait), .cmp_in(cmp_in), .cmp_power(cmp_power), .sample_hold(sample_hold),
		.dac_code(dac_code), .conversion_done_irq(irq), .result_suspect(suspect));

	sads_afe_model i_afe (.clk(clk), .cmp_power(cmp_power), .sample_hold(sample_hold),
		.dac_code(dac_code), .vin(vin), .cmp_in(cmp_in));

	// Counts, verdict, end of run
	task automatic report_and_stop();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	// Bus access: kind 0 read, 1 byte write, 2 bit write (d[2:0] bit, d[7] value)
	// Only issued while the clock runs
	task automatic acc(input logic [15:0] a, input int kind, input logic [7:0] d, input logic ew);
		int k;
		k = 0;
		@(posedge clk);
		cpu_addr <= a;
		cpu_rd <= (kind == 0);
		cpu_wr <= (kind == 1);
		cpu_bit_wr <= (kind == 2);
		cpu_bit_sel <= d[2:0];
		cpu_wdata <= (kind == 2) ? {7'h00, d[7]} : d;
		#1 `CHK("wait", ew, cpu_wait)
		// Hold the request through the wait cycle
		while (cpu_wait === 1'b1 && k < 8) begin
			@(posedge clk);
			#1 k++;
		end
		if (k >= 8) begin
			n_fail++;
			report_and_stop();
		end
		@(posedge clk);
		cpu_rd <= 1'b0;
		cpu_wr <= 1'b0;
		cpu_bit_wr <= 1'b0;
		#1 rd = cpu_rdata;
	endtask : acc

	// Clocks until the next completion pulse, bounded
	task automatic wdone(output int n);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (irq !== 1'b1 && n < 2000);
		if (n >= 2000) begin
			n_fail++;
			report_and_stop();
		end
	endtask : wdone

	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK("dac_rst", 10'h200, dac_code)
		acc(sads_pkg::MODE_ADDR, 0, 8'h00, 1'b0);
		`CHK("mode_rst", sads_pkg::MODE_RESET, rd)
		acc(sads_pkg::BYTE_ADDR, 0, 8'h00, 1'b1);
		`CHK("byte_rst", 8'h00, rd)
		// Bit 6 only: reads back zero, stays stopped
		acc(sads_pkg::MODE_ADDR, 1, 8'h40, 1'b1);
		acc(sads_pkg::MODE_ADDR, 0, 8'h00, 1'b0);
		`CHK("bit6", 8'h00, rd)
		`CHK("pwr_off", 1'b0, cmp_power)
		// Comparator alone by a bit write: powered, idle, settling
		acc(sads_pkg::MODE_ADDR, 2, 8'h80, 1'b1);
		acc(sads_pkg::MODE_ADDR, 0, 8'h00, 1'b0);
		`CHK("bitwr", 8'h01, rd)
		repeat (sads_pkg::SETTLE_CYC + 10) begin
			@(posedge clk);
			#1 `CHK("idle", 2'b10, {cmp_power, irq | sample_hold})
		end
		// Ordinary conversions, one row each
		for (i = 0; i < 12; i++) begin
			vin = rows[i][1][9:0];
			acc(sads_pkg::MODE_ADDR, 1, rows[i][0][7:0], 1'b1);
			wdone(cyc);
			wdone(cyc);
			wdone(cyc);
			`CHK("period", rows[i][2], cyc)
			acc(sads_pkg::WORD_ADDR_HI, 0, 8'h00, 1'b1);
			`CHK("word_hi", rows[i][1][9:2], rd)
			acc(sads_pkg::WORD_ADDR_LO, 0, 8'h00, 1'b1);
			`CHK("word_lo", {rows[i][1][1:0], 6'h00}, rd)
			acc(sads_pkg::BYTE_ADDR, 0, 8'h00, 1'b1);
			`CHK("byte", rows[i][1][9:2], rd)
			`CHK("settled", 1'b0, suspect)
			acc(sads_pkg::MODE_ADDR, 1, 8'h01, 1'b1);
		end
		// Run from fully stopped: first result flagged, next one clean
		acc(sads_pkg::MODE_ADDR, 1, 8'h00, 1'b1);
		`CHK("stopped", 1'b0, cmp_power)
		acc(sads_pkg::MODE_ADDR, 2, 8'h87, 1'b1);
		`CHK("run_pwr", 1'b1, cmp_power)
		wdone(cyc);
		repeat (2) @(posedge clk);
		`CHK("first", 1'b1, suspect)
		wdone(cyc);
		repeat (2) @(posedge clk);
		`CHK("second", 1'b0, suspect)
		// Unmapped address: no wait cycle
		acc(16'h0000, 0, 8'h00, 1'b0);
		acc(sads_pkg::MODE_ADDR, 2, 8'h07, 1'b1);
		acc(sads_pkg::MODE_ADDR, 0, 8'h00, 1'b0);
		`CHK("end_mode", 8'h00, rd)
		`CHK("end_pwr", 1'b0, cmp_power)
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire

// [verilog/sads_clkdiv.sv]
// Conversion clock divider producing a one-cycle enable
`timescale 1ns/1ps
`default_nettype none
module sads_clkdiv (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       run,      // Divider runs while high
	input  wire logic [2:0] tsel,     // Time select code
	output logic            tick      // One-cycle conversion clock enable
);
	logic [3:0] cnt_q;                // Cycle counter
	logic [3:0] div_w;                // Division ratio minus one

	// Codes 000..101 map to /12 /8 /6 /4 /3 /2
	assign div_w = (tsel == 3'd0) ? 4'd11 : (tsel == 3'd1) ? 4'd7 : (tsel == 3'd2) ? 4'd5 :
	               (tsel == 3'd3) ? 4'd3 : (tsel == 3'd4) ? 4'd2 : 4'd1;
	assign tick  = run && (cnt_q == div_w);

	// Count up to the ratio minus one, restart when stopped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 4'h0;
		end else if (!run || tick) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule : sads_clkdiv
`default_nettype wire

// [verilog/sads_pkg.sv]
// Package with register map, field positions and timing constants for the converter sequencer
`default_nettype none
package sads_pkg;
	localparam logic [15:0] MODE_ADDR    = 16'hff28;   // Mode register byte address
	localparam logic [15:0] WORD_ADDR_LO = 16'hff08;   // Result word, low byte
	localparam logic [15:0] WORD_ADDR_HI = 16'hff09;   // Result word, high byte
	localparam logic [15:0] BYTE_ADDR    = 16'hff1f;   // Result upper byte
	localparam logic [7:0]  MODE_RESET   = 8'h00;      // Mode register after reset
	localparam int          RUN_BIT      = 7;          // Conversion run
	localparam int          TSEL_LSB     = 3;          // Time select field low bit
	localparam int          RANGE_BIT    = 2;          // Upper range bit
	localparam int          LOWV_BIT     = 1;          // Low-voltage bit
	localparam int          CMP_BIT      = 0;          // Comparator enable
	localparam int          RES_BITS     = 10;         // Result width
	localparam int          STEPS_NORMAL = 22;         // Conversion clocks, low-voltage off
	localparam int          STEPS_LOWV   = 40;         // Conversion clocks, low-voltage on
	localparam int          CLK_MHZ      = 100;        // Clock rate
	localparam int          SETTLE_US    = 1;          // Comparator settle time
	localparam int          SETTLE_CYC   = SETTLE_US * CLK_MHZ; // Settle cycles, rounded up
	localparam logic [15:0] RESULT_RESET = 16'h0000;   // Result after reset
endpackage : sads_pkg
`default_nettype wire

// [verilog/sads_top.sv]
// Successive-approximation converter sequencer with CPU register port
// Behaviour
// - Completion copies result into both registers
// - Word register left-justified, low six zero
// - Byte register holds top eight bits
// - Result reads insert one wait cycle
// - Completion raises done interrupt pulse
// - Mode register byte/bit writable, resets zero
// - Both bits clear: fully stopped
// - Comparator only: powered, no conversion
// - Run starts conversion regardless of comparator
// - Model comparator settle, flag unreliable result
// - Mode writes take a wait cycle
// - Time select sets divider, low-voltage bit sets length
// - Converts back to back while running
// - Resolve MSB first, one bit every second step
`timescale 1ns/1ps
`default_nettype none
module sads_top (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [15:0] cpu_addr,     // CPU address
	input  wire logic        cpu_rd,       // Read strobe
	input  wire logic        cpu_wr,       // Byte write strobe
	input  wire logic        cpu_bit_wr,   // Single-bit write strobe
	input  wire logic [2:0]  cpu_bit_sel,  // Bit number for single-bit write
	input  wire logic [7:0]  cpu_wdata,    // Write data (bit 0 for single-bit)
	output logic [7:0]       cpu_rdata,    // Read data
	output logic             cpu_wait,     // Wait cycle request
	input  wire logic        cmp_in,       // Comparator decision from front end
	output logic             cmp_power,    // Comparator bias enable
	output logic             sample_hold,  // Sample and hold the input
	output logic [9:0]       dac_code,     // Trial code for resistor string
	output logic             conversion_done_irq, // Completion pulse
	output logic             result_suspect // Latest result taken before settle
);
	logic        rst_n;                  // Synchronised reset, second flop of the chain
	logic        cs1_q, cs2_q;           // Comparator synchroniser
	logic [7:0]  mode_q;                 // Mode register
	logic [9:0]  approximation_shift_reg; // Trial register
	logic [9:0]  mask_q;                 // Bit under trial
	logic [5:0]  step_q;                 // Conversion clock count
	logic [15:0] result_word_left_justified; // Word result
	logic [7:0]  result_upper_byte;      // Byte result
	logic [7:0]  settle_q;               // Comparator settle counter
	logic        started_early_q;        // Current conversion began unsettled
	logic        suspect_q;              // Output flag
	logic        done_q;                 // Completion pulse
	logic        wait_q;                 // Wait cycle issued
	logic [7:0]  rdata_q;                // Registered read data
	logic        conversion_run, comparator_enable, low_voltage_select;
	logic [2:0]  tsel;
	logic        tick, hit_mode, hit_res, acc, last_step, settled;
	logic [5:0]  total_w;
	logic [7:0]  bitwr_w;

	// Reset release through two flops, the rest of the design sees the second
	assign rst_n = rsx_q;
	logic rs0_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rs0_q <= 1'b0;
		end else begin
			rs0_q <= 1'b1;
		end
	end
	// Second stage follows the first only
	logic rsx_q;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rsx_q <= 1'b0;
		end else begin
			rsx_q <= rs0_q;
		end
	end

	// Field decode
	assign conversion_run     = mode_q[sads_pkg::RUN_BIT];
	assign comparator_enable  = mode_q[sads_pkg::CMP_BIT];
	assign low_voltage_select = mode_q[sads_pkg::LOWV_BIT];
	assign tsel               = mode_q[sads_pkg::TSEL_LSB +: 3];
	assign total_w   = low_voltage_select ? 6'(sads_pkg::STEPS_LOWV) : 6'(sads_pkg::STEPS_NORMAL);
	assign last_step = tick && (step_q == total_w - 6'd1);
	assign settled   = (settle_q == 8'(sads_pkg::SETTLE_CYC));
	assign hit_mode  = (cpu_addr == sads_pkg::MODE_ADDR);
	assign hit_res   = (cpu_addr == sads_pkg::WORD_ADDR_LO) || (cpu_addr == sads_pkg::WORD_ADDR_HI) ||
	                   (cpu_addr == sads_pkg::BYTE_ADDR);
	assign acc       = (cpu_rd && hit_res) || ((cpu_wr || cpu_bit_wr) && hit_mode);
	assign bitwr_w   = (mode_q & ~(8'h01 << cpu_bit_sel)) | ({7'h00, cpu_wdata[0]} << cpu_bit_sel);

	// Comparator power follows enable or run
	assign cmp_power   = comparator_enable || conversion_run;
	assign sample_hold = conversion_run && (step_q < 6'd2);
	assign dac_code    = approximation_shift_reg | mask_q;
	assign cpu_wait    = acc && !wait_q;
	assign cpu_rdata   = rdata_q;
	assign conversion_done_irq = done_q;
	assign result_suspect      = suspect_q;

	sads_clkdiv u_div (
		.clk  (clk),
		.rst_n(rst_n),
		.run  (conversion_run),
		.tsel (tsel),
		.tick (tick)
	);

	// Comparator input synchroniser
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs1_q <= 1'b0;
			cs2_q <= 1'b0;
		end else begin
			cs1_q <= cmp_in;
			cs2_q <= cs1_q;
		end
	end

	// Mode register, byte or bit write in the cycle after the wait cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= sads_pkg::MODE_RESET;
		end else if (hit_mode && wait_q && cpu_wr) begin
			mode_q <= cpu_wdata & 8'hbf;
		end else if (hit_mode && wait_q && cpu_bit_wr) begin
			mode_q <= bitwr_w & 8'hbf;
		end
	end

	// Wait flop and registered read data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_q  <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			wait_q <= acc && !wait_q;
			if (cpu_rd && hit_mode) begin
				rdata_q <= mode_q;
			end else if (cpu_rd && wait_q && cpu_addr == sads_pkg::WORD_ADDR_HI) begin
				rdata_q <= result_word_left_justified[15:8];
			end else if (cpu_rd && wait_q && cpu_addr == sads_pkg::WORD_ADDR_LO) begin
				rdata_q <= result_word_left_justified[7:0];
			end else if (cpu_rd && wait_q && cpu_addr == sads_pkg::BYTE_ADDR) begin
				rdata_q <= result_upper_byte;
			end
		end
	end

	// Comparator settle counter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			settle_q <= 8'h00;
		end else if (!cmp_power) begin
			settle_q <= 8'h00;
		end else if (!settled) begin
			settle_q <= settle_q + 8'h01;
		end
	end

	// Successive approximation sequence
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_q <= 6'd0;
			mask_q <= 10'h200;
			approximation_shift_reg <= 10'h000;
			started_early_q <= 1'b0;
		end else if (!conversion_run) begin
			step_q <= 6'd0;
			mask_q <= 10'h200;
			approximation_shift_reg <= 10'h000;
		end else if (tick) begin
			if (last_step) begin
				step_q <= 6'd0;
				mask_q <= 10'h200;
				approximation_shift_reg <= 10'h000;
			end else begin
				step_q <= step_q + 6'd1;
			end
			if (step_q == 6'd0) begin
				started_early_q <= !settled;
			end
			// Decide on even steps only: the comparator synchroniser needs three clocks
			// after each trial code, more than one conversion tick at the /2 setting
			if (step_q >= 6'd2 && !step_q[0] && mask_q != 10'h000 && !last_step) begin
				if (cs2_q) begin
					approximation_shift_reg <= approximation_shift_reg | mask_q;
				end
				mask_q <= mask_q >> 1;
			end
		end
	end

	// Result capture and completion pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			result_word_left_justified <= sads_pkg::RESULT_RESET;
			result_upper_byte          <= 8'h00;
			done_q                     <= 1'b0;
			suspect_q                  <= 1'b0;
		end else begin
			done_q <= conversion_run && last_step;
			if (conversion_run && last_step) begin
				result_word_left_justified <= {approximation_shift_reg, 6'h00};
				result_upper_byte          <= approximation_shift_reg[9:2];
				suspect_q                  <= started_early_q;
			end
		end
	end

	low_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
		result_word_left_justified[5:0] == 6'h00) else $error("low result bits not zero");
	byte_match_a: assert property (@(posedge clk) disable iff (!rst_n)
		result_upper_byte == result_word_left_justified[15:8]) else $error("byte result mismatch");
	done_load_a: assert property (@(posedge clk) disable iff (!rst_n)
		done_q |-> result_word_left_justified[15:6] == $past(approximation_shift_reg)) else $error("no load");
	wait_one_a: assert property (@(posedge clk) disable iff (!rst_n)
		(acc && !wait_q) |=> wait_q ##1 !wait_q) else $error("wait not one cycle");
	stop_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!conversion_run && !comparator_enable) |-> !cmp_power && !tick) else $error("not stopped");
	wait_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
		(!conversion_run && comparator_enable) |=> !done_q && step_q == 6'd0) else $error("converting idle");
	done_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		done_q |=> !done_q) else $error("done not a pulse");
	mode_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		(hit_mode && wait_q && cpu_wr) |=> mode_q == ($past(cpu_wdata) & 8'hbf)) else $error("mode write");
	msb_first_a: assert property (@(posedge clk) disable iff (!rst_n)
		(conversion_run && step_q == 6'd1 && tick) |=> mask_q == 10'h200) else $error("msb first");
endmodule : sads_top
`default_nettype wire
